// ===== rtl/psc_top.sv
// Pad state controller: pad state machine, registers and pad drive
`default_nettype none

// Function
// [RL1] Active/sleep: GPIO pads in or out, pull up, down or none.
// [RL2] GPIO 0,3,5,8,9,11 default pull-down, boot as inputs with pull-down.
// [RL3] Other GPIO pads default no pull, boot as inputs without pull.
// [RL4] Regulator enable low: GPIO and clock-request pads high-Z, no pull.
// [RL5] Keepers active except power-down; regulator inputs have none.
// [RL6] Active/sleep: clock request active high, open-drain or push-pull.
// [RL7] After reset, before software, clock request is active-high open-drain.
// [RL8] Both regulator inputs pulled down when running; software may disable.
// [RL9] Main regulator input keeps pull-down in power-down and at boot.
// [RL10] Board drives any input pad left without keeper or pull.
// [RL11] RF switch pads drive without pull, high-Z in power-down.
// [RL12] Every reset reloads each pad's pull and drive defaults.
module psc_top
  import psc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  input wire logic wireless_regulator_enable_i,
  input wire logic hibernate_regulator_enable_input_i,
  output logic wl_reg_pd_o,
  output logic hib_reg_pd_o,
  input wire logic [GPIO_N-1:0] gpio_in_i,
  output logic [GPIO_N-1:0] gpio_out_o,
  output logic [GPIO_N-1:0] gpio_oe_o,
  output logic [GPIO_N-1:0] gpio_pu_o,
  output logic [GPIO_N-1:0] gpio_pd_o,
  output logic [GPIO_N-1:0] gpio_keep_o,
  input wire logic clk_req_in_i,
  output logic clk_req_out_o,
  output logic clk_req_oe_o,
  output logic clk_req_keep_o,
  output logic [RF_N-1:0] rf_switch_control_pad_o,
  output logic [RF_N-1:0] rf_oe_o,
  output logic [RF_N-1:0] rf_keep_o,
  output logic [3:0] pad_state_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [GPIO_N-1:0] gpio_in_s;
  logic [2:0] misc_s;

  psc_sync #(.WIDTH(GPIO_N)) u_sync_gpio (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i(gpio_in_i),
    .sync_o(gpio_in_s)
  );

  psc_sync #(.WIDTH(3)) u_sync_misc (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .async_i({clk_req_in_i, hibernate_regulator_enable_input_i,
              ~wireless_regulator_enable_i}),
    .sync_o(misc_s)
  );

  // Main enable is synchronised inverted: the synchroniser clears to zero,
  // which must read as powered, or every reset would fake a power-down
  wire logic wl_en_s = !misc_s[0]; // [RL4]
  wire logic hib_en_s = misc_s[1];
  wire logic clk_req_s = misc_s[2];

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [CTRL_W-1:0] ctrl_q;
  logic [GPIO_N-1:0] gpio_oe_q;
  logic [GPIO_N-1:0] gpio_out_q;
  logic [GPIO_N*PULL_W-1:0] pull_q;
  logic [GPIO_N*PULL_W-1:0] pull_rst;
  logic [RF_N-1:0] rf_out_q;
  logic [DATA_W-1:0] rdata_d;
  logic boot_load;

  // Reset pull image built from the per-pad default mask
  for (genvar g = 0; g < GPIO_N; g++) begin : g_pull_rst
    assign pull_rst[g*PULL_W +: PULL_W] =
      PULL_DOWN_DEFAULT[g] ? PULL_DOWN_SETTING : NO_PULL_SETTING; // [RL2] [RL3]
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  wire logic wr_ctrl = reg_wr_i && (reg_addr_i == OFS_CTRL);
  wire logic wr_oe = reg_wr_i && (reg_addr_i == OFS_GPIO_OE);
  wire logic wr_out = reg_wr_i && (reg_addr_i == OFS_GPIO_OUT);
  wire logic wr_plo = reg_wr_i && (reg_addr_i == OFS_PULL_LO);
  wire logic wr_phi = reg_wr_i && (reg_addr_i == OFS_PULL_HI);
  wire logic wr_rf = reg_wr_i && (reg_addr_i == OFS_RF_OUT);

  localparam int PLO_W = PULL_PER_REG * PULL_W;
  localparam int PHI_W = (GPIO_N - PULL_PER_REG) * PULL_W;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  // Reset reloads every default; software state does not survive it
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_q <= CTRL_RST; // [RL12]
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      gpio_oe_q <= GPIO_ZERO; // [RL12]
    end else if (wr_oe) begin
      gpio_oe_q <= reg_wdata_i[GPIO_N-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      gpio_out_q <= GPIO_ZERO;
    end else if (wr_out) begin
      gpio_out_q <= reg_wdata_i[GPIO_N-1:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rf_out_q <= RF_ZERO;
    end else if (wr_rf) begin
      rf_out_q <= reg_wdata_i[RF_N-1:0];
    end
  end

  // A write landing on the default-load edge is lost, the load wins
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      pull_q <= '0;
    end else if (boot_load) begin
      pull_q <= pull_rst; // [RL12]
    end else begin
      if (wr_plo) pull_q[PLO_W-1:0] <= reg_wdata_i[PLO_W-1:0]; // [RL1]
      if (wr_phi) pull_q[PLO_W +: PHI_W] <= reg_wdata_i[PHI_W-1:0];
    end
  end

  // ****************************************************************
  // Pad state machine
  // ****************************************************************
  psc_state_t state_q;
  psc_state_t state_d;

  // Defaults are loaded into the pull image on the first cycle after
  // reset, so a constant reset value and the mask stay a single source
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      boot_load <= 1'b1;
    end else begin
      boot_load <= 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_BOOT: begin
        if (!wl_en_s) state_d = ST_PDOWN; // [RL4]
        else if (ctrl_q[CTRL_SW_READY]) state_d = ST_ACTIVE;
      end
      ST_ACTIVE: begin
        if (!wl_en_s) state_d = ST_PDOWN; // [RL4]
        else if (ctrl_q[CTRL_SLEEP]) state_d = ST_SLEEP;
      end
      ST_SLEEP: begin
        if (!wl_en_s) state_d = ST_PDOWN; // [RL4]
        else if (!ctrl_q[CTRL_SLEEP]) state_d = ST_ACTIVE;
      end
      ST_PDOWN: begin
        // Back from power-down via boot; ctrl_q and pull_q are kept, so CTRL_SW_READY set returns straight to active
        if (wl_en_s) state_d = ST_BOOT;
      end
      default: state_d = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= ST_BOOT; // [RL12]
    end else begin
      state_q <= state_d;
    end
  end

  wire logic run = (state_q == ST_ACTIVE) || (state_q == ST_SLEEP);
  wire logic pdown = (state_q == ST_PDOWN);

  // ****************************************************************
  // Per-pad controls
  // ****************************************************************
  psc_pad_t gpio_pad [GPIO_N];

  for (genvar g = 0; g < GPIO_N; g++) begin : g_pad
    psc_pad_cell u_cell (
      .state_i(state_q),
      .pull_i(pull_q[g*PULL_W +: PULL_W]),
      .boot_pd_i(PULL_DOWN_DEFAULT[g]),
      .oe_i(gpio_oe_q[g]),
      .out_i(gpio_out_q[g]),
      .pad_o(gpio_pad[g])
    );
  end

  // Clock request: open-drain pulls low only, push-pull drives both
  wire logic cr_pp = run && ctrl_q[CTRL_CLKREQ_PP]; // [RL6] [RL7]
  wire logic cr_val = run && ctrl_q[CTRL_CLKREQ_VAL]; // [RL6]
  wire logic cr_oe_d = !pdown && (cr_pp || !cr_val); // [RL4] [RL7]

  // Main regulator input keeps its pull-down outside run states
  wire logic wl_pd_d = run ? !ctrl_q[CTRL_WL_PD_OFF] : 1'b1; // [RL8] [RL9]
  wire logic hib_pd_d = run && !ctrl_q[CTRL_HIB_PD_OFF]; // [RL8]

  // ****************************************************************
  // GPIO output registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      gpio_out_o <= GPIO_ZERO;
      gpio_oe_o <= GPIO_ZERO;
      gpio_pu_o <= GPIO_ZERO;
      gpio_pd_o <= PULL_DOWN_DEFAULT; // [RL2] [RL3]
      gpio_keep_o <= ~GPIO_ZERO; // [RL5]
    end else begin
      for (int i = 0; i < GPIO_N; i++) begin
        gpio_out_o[i] <= gpio_pad[i].out;
        gpio_oe_o[i] <= gpio_pad[i].oe; // [RL4]
        gpio_pu_o[i] <= gpio_pad[i].pull_up;
        gpio_pd_o[i] <= gpio_pad[i].pull_dn;
        gpio_keep_o[i] <= gpio_pad[i].keep; // [RL5]
      end
    end
  end

  // ****************************************************************
  // Clock request, RF and regulator output registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      clk_req_out_o <= 1'b0;
      clk_req_oe_o <= 1'b1; // [RL7]
      clk_req_keep_o <= 1'b1;
      rf_switch_control_pad_o <= RF_ZERO;
      rf_oe_o <= ~RF_ZERO; // [RL11]
      rf_keep_o <= ~RF_ZERO;
      wl_reg_pd_o <= 1'b1; // [RL9]
      hib_reg_pd_o <= 1'b0;
      pad_state_o <= ST_BOOT;
    end else begin
      clk_req_out_o <= cr_val;
      clk_req_oe_o <= cr_oe_d;
      clk_req_keep_o <= !pdown; // [RL5]
      rf_switch_control_pad_o <= pdown ? RF_ZERO : rf_out_q;
      rf_oe_o <= pdown ? RF_ZERO : ~RF_ZERO; // [RL11]
      rf_keep_o <= pdown ? RF_ZERO : ~RF_ZERO; // [RL5]
      wl_reg_pd_o <= wl_pd_d;
      hib_reg_pd_o <= hib_pd_d;
      pad_state_o <= state_q;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped offsets read as zero; reads have no side effects
  localparam int STAT_W = $bits(psc_state_t) + 3;
  always_comb begin
    rdata_d = '0;
    unique case (reg_addr_i)
      OFS_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
      OFS_GPIO_OE: rdata_d[GPIO_N-1:0] = gpio_oe_q;
      OFS_GPIO_OUT: rdata_d[GPIO_N-1:0] = gpio_out_q;
      OFS_GPIO_IN: rdata_d[GPIO_N-1:0] = gpio_in_s;
      OFS_PULL_LO: rdata_d[PLO_W-1:0] = pull_q[PLO_W-1:0];
      OFS_PULL_HI: rdata_d[PHI_W-1:0] = pull_q[PLO_W +: PHI_W];
      OFS_RF_OUT: rdata_d[RF_N-1:0] = rf_out_q;
      OFS_STATUS: rdata_d[STAT_W-1:0] = {clk_req_s, hib_en_s, wl_en_s, state_q};
      default: rdata_d = '0;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : '0;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/psc_pkg.sv
// Shared constants, register map and types of the pad state controller
`default_nettype none
package psc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int GPIO_N = 17;
  localparam int RF_N = 10;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_GPIO_OE = 8'h04;
  localparam logic [7:0] OFS_GPIO_OUT = 8'h08;
  localparam logic [7:0] OFS_GPIO_IN = 8'h0C;
  localparam logic [7:0] OFS_PULL_LO = 8'h10;
  localparam logic [7:0] OFS_PULL_HI = 8'h14;
  localparam logic [7:0] OFS_RF_OUT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_SW_READY = 0;
  localparam int CTRL_SLEEP = 1;
  localparam int CTRL_CLKREQ_PP = 2;
  localparam int CTRL_CLKREQ_VAL = 3;
  localparam int CTRL_WL_PD_OFF = 4;
  localparam int CTRL_HIB_PD_OFF = 5;
  localparam int CTRL_W = 6;
  localparam logic [CTRL_W-1:0] CTRL_RST = 6'h00;

  // ****************************************************************
  // Pull settings, two bits per pad, sixteen pads per pull register
  // ****************************************************************
  localparam int PULL_W = 2;
  localparam int PULL_PER_REG = 16;
  localparam logic [1:0] NO_PULL_SETTING = 2'h0;
  localparam logic [1:0] PULL_DOWN_SETTING = 2'h1;
  localparam logic [1:0] PULL_UP_SETTING = 2'h2;
  // Pads 0, 3, 5, 8, 9 and 11 default to pull-down, the rest to none
  localparam logic [GPIO_N-1:0] PULL_DOWN_DEFAULT = 17'h0_0B29;
  localparam logic [GPIO_N-1:0] GPIO_ZERO = 17'h0_0000;
  localparam logic [RF_N-1:0] RF_ZERO = 10'h000;

  // ****************************************************************
  // Pad states, one-hot
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_BOOT   = 4'b0001,
    ST_ACTIVE = 4'b0010,
    ST_SLEEP  = 4'b0100,
    ST_PDOWN  = 4'b1000
  } psc_state_t;

  // Everything one pad needs from the controller
  typedef struct packed {
    logic out;
    logic oe;
    logic pull_up;
    logic pull_dn;
    logic keep;
  } psc_pad_t;

  localparam psc_pad_t PAD_OFF = 5'h00;

endpackage
`default_nettype wire

// ===== rtl/psc_sync.sv
// Two-flop synchroniser for pad inputs
`default_nettype none
module psc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ===== rtl/psc_pad_cell.sv
// Per-pad decode of pad state and pull setting into pad controls
`default_nettype none
module psc_pad_cell
  import psc_pkg::*;
(
  input wire psc_state_t state_i,
  input wire logic [1:0] pull_i,
  input wire logic boot_pd_i,
  input wire logic oe_i,
  input wire logic out_i,
  output psc_pad_t pad_o
);

  wire logic is_pdown = (state_i == ST_PDOWN);
  wire logic is_boot = (state_i == ST_BOOT);
  wire logic run = !is_pdown && !is_boot;

  // Pad is output only when running and software asks for it
  assign pad_o.oe = run && oe_i; // [RL1]
  assign pad_o.out = run && out_i;
  // Out of reset the pad sits as input with its default pull
  assign pad_o.pull_dn = is_boot ? boot_pd_i // [RL2] [RL3]
                       : run && (pull_i == PULL_DOWN_SETTING); // [RL1]
  assign pad_o.pull_up = run && (pull_i == PULL_UP_SETTING); // [RL1] [RL4]
  // Keeper off only in power-down
  assign pad_o.keep = !is_pdown; // [RL5]

endmodule
`default_nettype wire

// ===== test/psc_checker.sv
// Concurrent checks on the pad state controller ports
`default_nettype none
module psc_checker
  import psc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic wireless_regulator_enable_i,
  input wire logic wl_reg_pd_o,
  input wire logic [GPIO_N-1:0] gpio_oe_o,
  input wire logic [GPIO_N-1:0] gpio_pu_o,
  input wire logic [GPIO_N-1:0] gpio_pd_o,
  input wire logic [GPIO_N-1:0] gpio_keep_o,
  input wire logic clk_req_out_o,
  input wire logic clk_req_oe_o,
  input wire logic clk_req_keep_o,
  input wire logic [RF_N-1:0] rf_oe_o,
  input wire logic [RF_N-1:0] rf_keep_o,
  input wire logic [3:0] pad_state_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Outputs lag the state by one edge, so a state must hold for two
  sequence in_pdown; (pad_state_o == ST_PDOWN) [*2]; endsequence
  sequence in_boot; (pad_state_o == ST_BOOT) [*2]; endsequence
  sequence powered; (pad_state_o != ST_PDOWN) [*2]; endsequence
  sequence low_pwr; (pad_state_o inside {ST_PDOWN, ST_BOOT}) [*2]; endsequence
  chk_pdown_off: assert property (in_pdown |->
    gpio_oe_o == GPIO_ZERO && gpio_pu_o == GPIO_ZERO &&
    gpio_pd_o == GPIO_ZERO && !clk_req_oe_o) else $error("pad on in pdown");
  chk_keep_off: assert property (in_pdown |->
    gpio_keep_o == GPIO_ZERO && !clk_req_keep_o && rf_keep_o == RF_ZERO)
    else $error("keeper on in power-down");
  chk_keep_on: assert property (powered |->
    &gpio_keep_o && clk_req_keep_o && &rf_keep_o) else $error("keeper off");
  chk_boot_pads: assert property (in_boot |->
    gpio_pd_o == PULL_DOWN_DEFAULT && gpio_pu_o == GPIO_ZERO &&
    gpio_oe_o == GPIO_ZERO) else $error("boot pad setting wrong");
  chk_boot_clkreq: assert property (in_boot |->
    clk_req_oe_o && !clk_req_out_o) else $error("boot clock request wrong");
  chk_rf_drive: assert property (powered |-> &rf_oe_o)
    else $error("rf pad not driven");
  chk_rf_off: assert property (in_pdown |-> rf_oe_o == RF_ZERO)
    else $error("rf pad driven in power-down");
  chk_main_pd: assert property (low_pwr |-> wl_reg_pd_o)
    else $error("main regulator pull-down off");
  chk_pdown_entry: assert property ($fell(wireless_regulator_enable_i)
    |-> ##[1:4] pad_state_o == ST_PDOWN) else $error("no power-down");
endmodule
bind psc_top psc_checker i_chk (.clk_sys_i, .reset_i,
  .wireless_regulator_enable_i, .wl_reg_pd_o, .gpio_oe_o, .gpio_pu_o,
  .gpio_pd_o, .gpio_keep_o, .clk_req_out_o, .clk_req_oe_o, .clk_req_keep_o,
  .rf_oe_o, .rf_keep_o, .pad_state_o);
`default_nettype wire

// ===== test/psc_board.sv
// Board model: resolves pad line levels seen by the controller
`default_nettype none
module psc_board
  import psc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic [GPIO_N-1:0] drv_en_i,
  input wire logic [GPIO_N-1:0] drv_val_i,
  input wire logic [GPIO_N-1:0] out_i,
  input wire logic [GPIO_N-1:0] oe_i,
  input wire logic [GPIO_N-1:0] pu_i,
  input wire logic [GPIO_N-1:0] pd_i,
  input wire logic [GPIO_N-1:0] keep_i,
  input wire logic ck_out_i,
  input wire logic ck_oe_i,
  output logic [GPIO_N-1:0] lvl_o,
  output logic ck_lvl_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Line levels
  // ****************************************************************
  logic [GPIO_N-1:0] last_q = GPIO_ZERO;
  // A line nobody holds flips each cycle, so a float never reads clean
  always_comb begin
    for (int i = 0; i < GPIO_N; i++) begin
      if (oe_i[i])
        lvl_o[i] = out_i[i];
      else if (drv_en_i[i])
        lvl_o[i] = drv_val_i[i];
      else if (pu_i[i] | pd_i[i])
        lvl_o[i] = pu_i[i];
      else if (keep_i[i])
        lvl_o[i] = last_q[i];
      else
        lvl_o[i] = ~last_q[i];
    end
  end
  always_ff @(posedge clk_sys_i) last_q <= lvl_o;
  // Board pull-up on the open-drain clock request line
  assign ck_lvl_o = ck_oe_i ? ck_out_i : 1'b1;
endmodule
`default_nettype wire

// ===== test/tb.sv
// Self-checking testbench of the pad state controller
`default_nettype none
module tb
  import psc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Signals, tasks and sequence
  // ****************************************************************
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = 8'h00;
  logic [DATA_W-1:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic wireless_regulator_enable_i = 1'b1;
  logic hibernate_regulator_enable_input_i = 1'b1;
  logic [GPIO_N-1:0] drv_en = GPIO_ZERO;
  logic [GPIO_N-1:0] drv_val = GPIO_ZERO;
  logic [DATA_W-1:0] reg_rdata_o, d;
  logic [GPIO_N-1:0] gpio_in_i, gpio_out_o, gpio_oe_o, gpio_pu_o;
  logic [GPIO_N-1:0] gpio_pd_o, gpio_keep_o;
  logic clk_req_in_i, clk_req_out_o, clk_req_oe_o, clk_req_keep_o;
  logic wl_reg_pd_o, hib_reg_pd_o;
  logic [RF_N-1:0] rf_switch_control_pad_o, rf_oe_o, rf_keep_o;
  logic [3:0] pad_state_o;
  logic [7:0] ck_ctl [4] = '{8'h09, 8'h01, 8'h0D, 8'h05};
  logic [1:0] ck_exp [4] = '{2'h1, 2'h2, 2'h3, 2'h2};
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  psc_top i_dut (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .wireless_regulator_enable_i,
    .hibernate_regulator_enable_input_i, .wl_reg_pd_o, .hib_reg_pd_o,
    .gpio_in_i, .gpio_out_o, .gpio_oe_o, .gpio_pu_o, .gpio_pd_o, .gpio_keep_o,
    .clk_req_in_i, .clk_req_out_o, .clk_req_oe_o, .clk_req_keep_o,
    .rf_switch_control_pad_o, .rf_oe_o, .rf_keep_o, .pad_state_o);
  psc_board i_board (.clk_sys_i, .drv_en_i(drv_en), .drv_val_i(drv_val),
    .out_i(gpio_out_o), .oe_i(gpio_oe_o), .pu_i(gpio_pu_o), .pd_i(gpio_pd_o),
    .keep_i(gpio_keep_o), .ck_out_i(clk_req_out_o), .ck_oe_i(clk_req_oe_o),
    .lvl_o(gpio_in_i), .ck_lvl_o(clk_req_in_i));
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic cmp(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // Waits for a state, then one edge more for the pad outputs
  task automatic wait_st(input logic [3:0] s);
    int n;
    n = 0;
    #1;
    while (pad_state_o !== s && n < 8) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    cmp("state", {28'h0, s}, {28'h0, pad_state_o});
    @(posedge clk_sys_i);
    #1;
  endtask
  task automatic conclude();
    if (num_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 cmp("boot pd", 32'(PULL_DOWN_DEFAULT), 32'(gpio_pd_o));
    cmp("boot pu oe", 32'h0000_0000, 32'(gpio_pu_o | gpio_oe_o));
    cmp("boot ck", 32'h0000_0002, {30'h0, clk_req_oe_o, clk_req_out_o});
    cmp("boot rf", 32'h0000_03FF, 32'(rf_oe_o));
    cmp("boot reg pd", 32'h0000_0002, {30'h0, wl_reg_pd_o, hib_reg_pd_o});
    wr_reg(OFS_CTRL, 32'h0000_0001);
    wait_st(ST_ACTIVE);
    cmp("run reg pd", 32'h0000_0003, {30'h0, wl_reg_pd_o, hib_reg_pd_o});
    // Pads 0 to 3 take codes up, down, none and the spare code
    wr_reg(OFS_PULL_LO, 32'h0000_00C6);
    wr_reg(OFS_PULL_HI, 32'h0000_0002);
    wr_reg(OFS_GPIO_OUT, 32'h0001_0010);
    wr_reg(OFS_GPIO_OE, 32'h0001_0010);
    wr_reg(OFS_RF_OUT, 32'h0000_02A5);
    drv_en <= 17'h0_0004;
    drv_val <= 17'h0_0004;
    repeat (6) @(posedge clk_sys_i);
    #1 cmp("pull up", 32'h0001_0001, 32'(gpio_pu_o));
    cmp("pull down", 32'h0000_0002, 32'(gpio_pd_o));
    cmp("out", 32'h0001_0010, 32'(gpio_oe_o & gpio_out_o));
    cmp("rf out", 32'h0000_02A5, 32'(rf_switch_control_pad_o));
    rd_reg(OFS_GPIO_IN);
    cmp("pad in", 32'h0001_0015, d & 32'h0001_0017);
    rd_reg(OFS_PULL_LO);
    cmp("pull reg", 32'h0000_00C6, d);
    rd_reg(8'h20);
    cmp("unmapped", 32'h0000_0000, d);
    for (int i = 0; i < 4; i++) begin
      wr_reg(OFS_CTRL, {24'h0, ck_ctl[i]});
      repeat (2) @(posedge clk_sys_i);
      #1 cmp("ck", {30'h0, ck_exp[i]}, {30'h0, clk_req_oe_o, clk_req_in_i});
    end
    wr_reg(OFS_CTRL, 32'h0000_0033);
    wait_st(ST_SLEEP);
    cmp("sleep reg pd", 32'h0000_0000, {30'h0, wl_reg_pd_o, hib_reg_pd_o});
    cmp("sleep pu", 32'h0001_0001, 32'(gpio_pu_o));
    cmp("keep", 32'h0001_FFFF, 32'(gpio_keep_o));
    rd_reg(OFS_STATUS);
    cmp("status", 32'h0000_0034, d);
    @(posedge clk_sys_i) wireless_regulator_enable_i <= 1'b0;
    wait_st(ST_PDOWN);
    cmp("pd pads", 32'h0000_0000, 32'(gpio_oe_o | gpio_pu_o | gpio_pd_o));
    cmp("pd keep", 32'h0000_0000, {30'h0, clk_req_oe_o, clk_req_keep_o});
    cmp("pd rf", 32'h0000_0000, 32'(rf_oe_o | rf_keep_o));
    cmp("pd rf out", 32'h0000_0000, 32'(rf_switch_control_pad_o));
    cmp("pd reg pd", 32'h0000_0002, {30'h0, wl_reg_pd_o, hib_reg_pd_o});
    @(posedge clk_sys_i) wireless_regulator_enable_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b1;
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    wr_reg(OFS_CTRL, 32'h0000_0001);
    wait_st(ST_ACTIVE);
    cmp("reload pd", 32'(PULL_DOWN_DEFAULT), 32'(gpio_pd_o));
    cmp("reload pu", 32'h0000_0000, 32'(gpio_pu_o));
    conclude();
  end
endmodule
`default_nettype wire
